// ===== nsc_nmi_status_control.sv
`timescale 1ns/1ps
//
// What this block does
// - Parity error sets status bit 7; NMI allowed only while control bit 2 is 0.
// - Parity status clears when control bit 2 goes one then zero.
// - Channel check error sets status bit 6; NMI allowed while control bit 3 is 0.
// - Channel status clears when control bit 3 goes one then zero.
// - Fail-safe expiry sets extended bit 7; enabled by bit 2; cleared zero-then-one.
// - Bus timeout sets extended bit 6; NMI enabled while extended bit 3 is one.
// - Timeout status clears when extended bit 3 goes zero then one.
// - Bus reset output asserts on timeout, drops when timeout status clears.
// - Extended bit 4 records short timeout (one) or long timeout (zero).
// - Software port write sets extended bit 5; enabled by bit 1; cleared zero-then-one.
// - Any write to software port requests NMI when enabled; port is write only.
// - Extended bit 0 drives bus reset output; software holds it eight clocks.
// - Mask port top bit gates all NMI sources; writing 80h masks NMI.
// - One mask-port write updates both mask bit and six-bit clock address.
// - After reset the extended port reads zero; the status port reads zero except bits 1:0, which show sc_low_bits.
//
module nsc_nmi_status_control
	import nsc_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 io_rd,
	input  wire logic                 io_wr,
	input  wire logic [15:0]          io_addr,
	input  wire logic [7:0]           io_wdata,
	output logic      [7:0]           io_rdata,
	output logic                      io_rdata_valid,
	input  wire logic                 parity_error_n,
	input  wire logic                 expansion_channel_error_n,
	input  wire logic                 failsafe_expired,
	input  wire logic                 bus_timeout_short,
	input  wire logic                 bus_timeout_long,
	input  wire logic [3:0]           sc_low_bits,
	output logic                      nmi_request,
	output logic                      bus_reset_output,
	output logic [NSC_RTC_W-1:0]      rtc_address
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus access and decode

	nsc_io_s  io;
	nsc_src_s src;
	logic     wr_sc;
	logic     wr_msk;
	logic     wr_ex;
	logic     wr_sw;
	logic     rd_sc;
	logic     rd_ex;

	always_comb begin
		io.rd         = io_rd;
		io.wr         = io_wr;
		io.addr       = io_addr;
		io.wdata      = io_wdata;
		src.parity        = ~parity_error_n;
		src.channel       = ~expansion_channel_error_n;
		src.failsafe      = failsafe_expired;
		src.timeout_short = bus_timeout_short;
		src.timeout_long  = bus_timeout_long;
	end

	nsc_decode u_decode (
		.io     (io),
		.wr_sc  (wr_sc),
		.wr_msk (wr_msk),
		.wr_ex  (wr_ex),
		.wr_sw  (wr_sw),
		.rd_sc  (rd_sc),
		.rd_ex  (rd_ex)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	logic [7:0]           sc_ctl;
	logic [7:0]           ex_ctl;
	logic                 nmi_mask;

	// Status/control port: all eight written bits are stored; only control bits 3 and 2 are used
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sc_ctl <= NSC_SC_RESET;
		end else if (wr_sc) begin
			sc_ctl <= io_wdata;
		end
	end

	// Extended port: enables and bus reset are writable, status bits are not
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ex_ctl <= NSC_EX_RESET;
		end else if (wr_ex) begin
			ex_ctl <= io_wdata;
		end
	end

	// One write sets mask and clock pointer together; reads are not supported
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nmi_mask    <= NSC_MSK_RESET[NSC_MASK_BIT];
			rtc_address <= NSC_MSK_RESET[NSC_RTC_W-1:0];
		end else if (wr_msk) begin
			nmi_mask    <= io_wdata[NSC_MASK_BIT];
			rtc_address <= io_wdata[NSC_RTC_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky status flags

	logic st_parity;
	logic st_channel;
	logic st_failsafe;
	logic st_timeout;
	logic st_soft;
	logic timeout_short_flag;
	logic timeout_event;

	assign timeout_event = src.timeout_short | src.timeout_long;

	// Parity: arms on one, clears on return to zero
	nsc_sticky #(.ARM_LEVEL(1'b1)) u_parity (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.set_event (src.parity),
		.ctl_bit   (sc_ctl[NSC_SC_PARITY_CLEAR]),
		.flag      (st_parity)
	);

	nsc_sticky #(.ARM_LEVEL(1'b1)) u_channel (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.set_event (src.channel),
		.ctl_bit   (sc_ctl[NSC_SC_CHANNEL_CLEAR]),
		.flag      (st_channel)
	);

	// Extended sources arm on zero, clear on return to one
	nsc_sticky #(.ARM_LEVEL(1'b0)) u_failsafe (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.set_event (src.failsafe),
		.ctl_bit   (ex_ctl[NSC_EX_FAILSAFE_ENABLE]),
		.flag      (st_failsafe)
	);

	nsc_sticky #(.ARM_LEVEL(1'b0)) u_timeout (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.set_event (timeout_event),
		.ctl_bit   (ex_ctl[NSC_EX_TIMEOUT_ENABLE]),
		.flag      (st_timeout)
	);

	nsc_sticky #(.ARM_LEVEL(1'b0)) u_soft (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.set_event (wr_sw),
		.ctl_bit   (ex_ctl[NSC_EX_SOFT_ENABLE]),
		.flag      (st_soft)
	);

	// Timeout length: short wins if both fire together
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timeout_short_flag <= 1'b0;
		end else if (timeout_event) begin
			timeout_short_flag <= src.timeout_short;
		end else if (!st_timeout) begin
			timeout_short_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	logic next_nmi;

	// Enabled status ORed together; the global mask overrides everything
	always_comb begin
		next_nmi = (st_parity   & ~sc_ctl[NSC_SC_PARITY_CLEAR])
		         | (st_channel  & ~sc_ctl[NSC_SC_CHANNEL_CLEAR])
		         | (st_failsafe &  ex_ctl[NSC_EX_FAILSAFE_ENABLE])
		         | (st_timeout  &  ex_ctl[NSC_EX_TIMEOUT_ENABLE])
		         | (st_soft     &  ex_ctl[NSC_EX_SOFT_ENABLE]);
		if (nmi_mask) begin
			next_nmi = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nmi_request <= 1'b0;
		end else begin
			nmi_request <= next_nmi;
		end
	end

	// Timeout status or software bit drives bus reset; software times the hold
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_reset_output <= 1'b0;
		end else begin
			bus_reset_output <= st_timeout | ex_ctl[NSC_EX_BUS_RESET];
		end
	end

	// Read data registered one cycle after the read strobe
	// Length bit is gated by the timeout status: its own flag drops one edge late
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			io_rdata       <= 8'h00;
			io_rdata_valid <= 1'b0;
		end else begin
			io_rdata_valid <= rd_sc | rd_ex;
			if (rd_sc) begin
				io_rdata <= {st_parity, st_channel, 2'b00, sc_ctl[3:2], sc_low_bits[1:0]};
			end else if (rd_ex) begin
				io_rdata <= {st_failsafe, st_timeout, st_soft,
					(timeout_short_flag & st_timeout), ex_ctl[3:0]};
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

endmodule // nsc_nmi_status_control

// ===== nsc_pkg.sv
package nsc_pkg;

	// I/O port addresses
	localparam logic [15:0] NSC_ADDR_STATUS_CONTROL   = 16'h0061;
	localparam logic [15:0] NSC_ADDR_RTC_INDEX        = 16'h0070;
	localparam logic [15:0] NSC_ADDR_EXT_STATUS_CTL   = 16'h0461;
	localparam logic [15:0] NSC_ADDR_SOFTWARE_TRIGGER = 16'h0462;

	// Status/control port bit positions
	localparam int NSC_SC_PARITY_STATUS  = 7;
	localparam int NSC_SC_CHANNEL_STATUS = 6;
	localparam int NSC_SC_CHANNEL_CLEAR  = 3;
	localparam int NSC_SC_PARITY_CLEAR   = 2;

	// Extended port bit positions
	localparam int NSC_EX_FAILSAFE_STATUS = 7;
	localparam int NSC_EX_TIMEOUT_STATUS  = 6;
	localparam int NSC_EX_SOFT_STATUS     = 5;
	localparam int NSC_EX_SHORT_TIMEOUT   = 4;
	localparam int NSC_EX_TIMEOUT_ENABLE  = 3;
	localparam int NSC_EX_FAILSAFE_ENABLE = 2;
	localparam int NSC_EX_SOFT_ENABLE     = 1;
	localparam int NSC_EX_BUS_RESET       = 0;

	// Mask port layout
	localparam int NSC_MASK_BIT = 7;
	localparam int NSC_RTC_W    = 6;

	// Reset values
	localparam logic [7:0] NSC_SC_RESET  = 8'h00;
	localparam logic [7:0] NSC_EX_RESET  = 8'h00;
	localparam logic [7:0] NSC_MSK_RESET = 8'h00;

	// Minimum bus reset hold, in bus clocks
	localparam int NSC_BUS_RESET_HOLD = 8;

	// One I/O access from the bus side
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} nsc_io_s;

	// Error source events for one cycle
	typedef struct packed {
		logic parity;
		logic channel;
		logic failsafe;
		logic timeout_short;
		logic timeout_long;
	} nsc_src_s;

endpackage

// ===== nsc_sticky.sv
`timescale 1ns/1ps
// Sticky status flag cleared by a two-step control-bit sequence
module nsc_sticky
	import nsc_pkg::*;
#(
	parameter logic ARM_LEVEL = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic set_event,
	input  wire logic ctl_bit,
	output logic      flag
);

	logic armed;

	// Arm when control reaches ARM_LEVEL, clear on return to the other level
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed <= 1'b0;
		end else begin
			armed <= (ctl_bit == ARM_LEVEL);
		end
	end

	// Set wins over clear, so an event during the clear is kept
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (set_event) begin
			flag <= 1'b1;
		end else if (armed && (ctl_bit != ARM_LEVEL)) begin
			flag <= 1'b0;
		end
	end

endmodule // nsc_sticky

// ===== nsc_decode.sv
`timescale 1ns/1ps
// Port address decoder for the four NMI ports
module nsc_decode
	import nsc_pkg::*;
(
	input  nsc_io_s   io,
	output logic      wr_sc,
	output logic      wr_msk,
	output logic      wr_ex,
	output logic      wr_sw,
	output logic      rd_sc,
	output logic      rd_ex
);

	// Pure decode; registered use happens in the top
	always_comb begin
		wr_sc  = io.wr && (io.addr == NSC_ADDR_STATUS_CONTROL);
		wr_msk = io.wr && (io.addr == NSC_ADDR_RTC_INDEX);
		wr_ex  = io.wr && (io.addr == NSC_ADDR_EXT_STATUS_CTL);
		wr_sw  = io.wr && (io.addr == NSC_ADDR_SOFTWARE_TRIGGER);
		rd_sc  = io.rd && (io.addr == NSC_ADDR_STATUS_CONTROL);
		rd_ex  = io.rd && (io.addr == NSC_ADDR_EXT_STATUS_CTL);
	end

endmodule // nsc_decode

// ===== nsc_checker.sv
`timescale 1ns/1ps
module nsc_checker
	import nsc_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 rst,
	input wire logic                 io_rd,
	input wire logic                 io_wr,
	input wire logic [15:0]          io_addr,
	input wire logic [7:0]           io_wdata,
	input wire logic [7:0]           io_rdata,
	input wire logic                 io_rdata_valid,
	input wire logic                 parity_error_n,
	input wire logic                 bus_timeout_short,
	input wire logic                 nmi_request,
	input wire logic                 bus_reset_output,
	input wire logic [NSC_RTC_W-1:0] rtc_address
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic msk;
	logic par_off;
	logic soft_on;
	logic [NSC_RTC_W-1:0] wr_low;
	// Clock pointer field of the write data, so $past sees a plain signal
	assign wr_low = io_wdata[NSC_RTC_W-1:0];
	// Shadow of software control bits, so expectations need no peek inside
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			msk <= 1'b0;
			par_off <= 1'b0;
			soft_on <= 1'b0;
		end else if (io_wr) begin
			if (io_addr == NSC_ADDR_RTC_INDEX) msk <= io_wdata[NSC_MASK_BIT];
			if (io_addr == NSC_ADDR_STATUS_CONTROL) par_off <= io_wdata[NSC_SC_PARITY_CLEAR];
			if (io_addr == NSC_ADDR_EXT_STATUS_CTL) soft_on <= io_wdata[NSC_EX_SOFT_ENABLE];
		end
	end
	sequence s_mask_wr;
		io_wr && io_addr == NSC_ADDR_RTC_INDEX;
	endsequence
	sequence s_status_rd;
		io_rd && (io_addr == NSC_ADDR_STATUS_CONTROL || io_addr == NSC_ADDR_EXT_STATUS_CTL);
	endsequence
	// Status reads must be answered; no answer or nonzero data may appear without a read
	a_read_answer: assert property (s_status_rd |=> io_rdata_valid)
		else $error("status read not answered");
	a_no_stray_valid: assert property (!io_rd |=> !io_rdata_valid)
		else $error("read answer without a status read");
	a_idle_rdata: assert property (!io_rdata_valid |-> io_rdata == 8'h00)
		else $error("read data not zero while idle");
	a_rtc_pointer: assert property (s_mask_wr |=> rtc_address == $past(wr_low))
		else $error("clock address not taken from mask write");
	a_mask_gates_nmi: assert property (msk && $past(msk) |-> !nmi_request)
		else $error("request while masked");
	a_parity_nmi: assert property (!parity_error_n && !par_off && !msk |-> ##[1:2] nmi_request)
		else $error("parity error gave no request");
	a_soft_nmi: assert property (io_wr && io_addr == NSC_ADDR_SOFTWARE_TRIGGER && soft_on && !msk
		|-> ##[1:3] nmi_request)
		else $error("software port gave no request");
	a_timeout_drive: assert property (bus_timeout_short |-> ##[1:2] bus_reset_output)
		else $error("timeout did not drive bus reset");
	a_bus_reset_bit: assert property (io_wr && io_addr == NSC_ADDR_EXT_STATUS_CTL
		&& io_wdata[NSC_EX_BUS_RESET] |-> ##[1:2] bus_reset_output)
		else $error("reset bit did not drive bus reset");
endmodule // nsc_checker
////////////////////////////////////////
bind nsc_nmi_status_control nsc_checker u_chk (.clk_sys, .rst, .io_rd, .io_wr, .io_addr,
	.io_wdata, .io_rdata, .io_rdata_valid, .parity_error_n, .bus_timeout_short,
	.nmi_request, .bus_reset_output, .rtc_address);

// ===== nsc_host_model.sv
`timescale 1ns/1ps
// Host software: issues I/O cycles and keeps the clear sequences
module nsc_host_model
	import nsc_pkg::*;
(
	input  wire logic       clk_sys,
	output logic            io_rd,
	output logic            io_wr,
	output logic [15:0]     io_addr,
	output logic [7:0]      io_wdata,
	input  wire logic [7:0] io_rdata,
	input  wire logic       io_rdata_valid
);
	initial begin
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
	end
	// Released lines show the inverse, so stale values never look valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		io_wr = 1'b1;
		io_addr = a;
		io_wdata = d;
		@(negedge clk_sys);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	// Answer is registered at the taking edge, so it is there at the next negedge, half a cycle later
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_sys);
		io_rd = 1'b1;
		io_addr = a;
		@(negedge clk_sys);
		v = io_rdata_valid;
		d = io_rdata;
		io_rd = 1'b0;
		io_addr = ~a;
	endtask
	// Clear: flip the control bit away from its resting level, then back
	task automatic clr(input logic [15:0] a, input logic [7:0] rest, input int b);
		wr(a, rest ^ (8'h01 << b));
		wr(a, rest);
	endtask
endmodule // nsc_host_model

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb
	import nsc_pkg::*;
;
	localparam logic [15:0] A_SC = NSC_ADDR_STATUS_CONTROL;
	localparam logic [15:0] A_EX = NSC_ADDR_EXT_STATUS_CTL;
	localparam logic [7:0] EXP [6] = '{8'h80, 8'h40, 8'h8E, 8'h5E, 8'h4E, 8'h2E};
	localparam int CB [6] = '{2, 3, 2, 3, 3, 1};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic io_rd, io_wr, io_rdata_valid, nmi_request, bus_reset_output, v;
	logic par_n = 1'b1, chn_n = 1'b1, fs = 1'b0, tos = 1'b0, tol = 1'b0;
	logic [3:0] sc_low_bits = 4'h0;
	logic [15:0] io_addr, a;
	logic [7:0] io_wdata, io_rdata, d, r;
	logic [NSC_RTC_W-1:0] rtc_address;
	int err_total = 0;
	int total_checks = 0;
	always #20 clk_sys = ~clk_sys;
	nsc_nmi_status_control uut (.clk_sys, .rst, .io_rd, .io_wr, .io_addr, .io_wdata, .io_rdata,
		.io_rdata_valid, .parity_error_n(par_n), .expansion_channel_error_n(chn_n),
		.failsafe_expired(fs), .bus_timeout_short(tos), .bus_timeout_long(tol), .sc_low_bits,
		.nmi_request, .bus_reset_output, .rtc_address);
	nsc_host_model host (.clk_sys, .io_rd, .io_wr, .io_addr, .io_wdata, .io_rdata, .io_rdata_valid);
	////////////////////////////////////////
	task automatic rdc(input logic [15:0] ad, input logic [7:0] e);
		host.rd(ad, d, v);
		`CHK("valid", 1'b1, v)
		`CHK("rdata", e, d)
	endtask
	// Source 5 is the software port; the rest are one-cycle input events
	task automatic fire(input int k);
		if (k == 5) host.wr(NSC_ADDR_SOFTWARE_TRIGGER, 8'h5A);
		else begin
			@(negedge clk_sys);
			{par_n, chn_n, fs, tos, tol} = {k != 0, k != 1, k == 2, k == 3, k == 4};
			@(negedge clk_sys);
			{par_n, chn_n, fs, tos, tol} = 5'b11000;
		end
		repeat (2) @(negedge clk_sys);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		rdc(A_SC, 8'h00);
		rdc(A_EX, 8'h00);
		host.wr(A_EX, 8'h0E);
		for (int k = 0; k < 6; k++) begin
			a = (k < 2) ? A_SC : A_EX;
			r = (k < 2) ? 8'h00 : 8'h0E;
			fire(k);
			rdc(a, EXP[k]);
			`CHK("nmi", 1'b1, nmi_request)
			`CHK("bus reset", k == 3 || k == 4, bus_reset_output)
			host.clr(a, r, CB[k]);
			rdc(a, r);
			`CHK("nmi off", 1'b0, nmi_request)
			`CHK("bus reset off", 1'b0, bus_reset_output)
		end
		fire(0);
		host.wr(NSC_ADDR_RTC_INDEX, 8'h80);
		repeat (2) @(negedge clk_sys);
		`CHK("masked", 1'b0, nmi_request)
		`CHK("rtc", 6'h00, rtc_address)
		host.wr(NSC_ADDR_RTC_INDEX, 8'h15);
		repeat (2) @(negedge clk_sys);
		`CHK("unmasked", 1'b1, nmi_request)
		`CHK("rtc", 6'h15, rtc_address)
		host.clr(A_SC, 8'h00, 2);
		// Gated parity still latches; completing the sequence then clears it
		host.wr(A_SC, 8'h04);
		fire(0);
		`CHK("gated", 1'b0, nmi_request)
		rdc(A_SC, 8'h84);
		host.wr(A_SC, 8'h00);
		rdc(A_SC, 8'h00);
		host.wr(A_EX, 8'h0F);
		repeat (8) @(negedge clk_sys);
		`CHK("hold", 1'b1, bus_reset_output)
		host.wr(A_EX, 8'h0E);
		repeat (2) @(negedge clk_sys);
		`CHK("release", 1'b0, bus_reset_output)
		host.wr(16'h0063, 8'hFF);
		host.rd(16'h0063, d, v);
		`CHK("unmapped", 1'b0, v)
		host.rd(NSC_ADDR_SOFTWARE_TRIGGER, d, v);
		`CHK("write only", 1'b0, v)
		sc_low_bits = 4'hE;
		rdc(A_SC, 8'h02);
		// Mid-run reset with a software request pending must leave both ports idle
		fire(5);
		`CHK("soft", 1'b1, nmi_request)
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		rdc(A_EX, 8'h00);
		rdc(A_SC, 8'h02);
		`CHK("nmi after reset", 1'b0, nmi_request)
		`CHK("bus reset after reset", 1'b0, bus_reset_output)
		`CHK("rtc after reset", 6'h00, rtc_address)
		report_and_stop;
	end
endmodule // tb
